// >>> logic/fcs_flash_config.sv
// Flash clock divider, option copy and key-access configuration registers.
//
// What this block does
// - Divider prescale and divisor bits readable always, writable only once after reset.
// - Divider-loaded flag is read-only, cleared by reset, set by first divider write.
// - Program and erase are disabled until divider-loaded flag is set.
// - Prescale bit picks bus clock or bus clock divided by eight.
// - Divider divides selected input by divisor field plus one.
// - Each flash clock enable pulse lasts one bus clock cycle.
// - Option register copies the nonvolatile option byte during reset only.
// - Key enable bit zero forbids the key from disengaging security.
// - Only secured firmware writes count as key comparison writes, never debug.
// - Eight matching key bytes in order disengage security until reset.
// - Redirection-disable bit one disables vector redirection, zero enables it.
// - Security code 2'b10 alone means unsecured; other codes mean secured.
// - While secured, block memory access from unsecured sources and debug.
// - Successful key entry or blank check sets security code to unsecured.
// - Key-access bit steers key-range writes to key compare or command start.
// - Clearing key-access after eight key writes compares and unsecures on match.
// - Program or erase before divider write flags access error and is ignored.
`timescale 1ns/1ps
module fcs_flash_config (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave port.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Option byte read from nonvolatile storage, stable during reset.
	input wire logic [7:0] nonvolatile_option_byte,
	// Stored backdoor key, byte 0 in the low bits.
	input wire logic [63:0] stored_backdoor_key,
	// Flash-side writes at any address, key address range included.
	input wire logic flash_write,
	input wire logic [15:0] flash_write_addr,
	input wire logic [7:0] flash_write_data,
	input wire logic flash_write_from_debug,
	input wire logic flash_write_from_secure,
	// Result of a completed blank check with the array erased.
	input wire logic blank_check_pass,
	// Memory access request from an unsecured source or debug.
	input wire logic unsecured_access,
	// Outputs to the command sequencer and the system.
	output logic program_erase_enable,
	output logic flash_clock_enable,
	output logic command_start,
	output logic access_error,
	output logic secured,
	output logic backdoor_key_enable,
	output logic redirection_disable,
	output logic access_blocked
);
	// Bus address phase capture.
	logic wr_pend_reg;
	logic [7:0] addr_pend_reg;
	logic [31:0] hrdata_reg;
	// Register state.
	logic divider_loaded_reg;
	logic prescale_reg;
	logic [5:0] divisor_reg;
	logic [7:0] option_reg;
	logic key_access_reg;
	logic [7:0] key_seen_reg;
	logic key_match_reg;
	logic access_error_reg;
	// Clock divider state.
	logic [2:0] pre_cnt_reg;
	logic [5:0] div_cnt_reg;
	logic fclk_en_reg;
	// Output flops.
	logic cmd_start_reg;
	logic blocked_reg;
	logic secured_reg;

	// Address decode of the bus. Writes land in the data phase, when hwdata
	// stands, so the write decodes use the address captured a cycle before.
	wire logic bus_take = hsel & hready & htrans[fcs_pkg::fcs_htrans_active_bit];
	wire logic wr_div = wr_pend_reg &
		(addr_pend_reg == fcs_pkg::fcs_off_clock_divider);
	wire logic wr_cfg = wr_pend_reg &
		(addr_pend_reg == fcs_pkg::fcs_off_configuration);
	wire logic wr_stat = wr_pend_reg &
		(addr_pend_reg == fcs_pkg::fcs_off_status);
	wire logic [7:0] divider_value = {divider_loaded_reg, prescale_reg,
		divisor_reg};
	wire logic [7:0] config_value = {2'h0, key_access_reg, 5'h00};
	wire logic [7:0] status_value = {6'h00, key_match_reg, access_error_reg};
	logic [7:0] read_value;
	// Unmapped offsets read as zero and accept writes silently. The mux
	// follows the live address phase, so read data are ready in the data
	// phase and the slave never needs a wait state.
	always_comb begin
		if (haddr == fcs_pkg::fcs_off_clock_divider) begin
			read_value = divider_value;
		end else if (haddr == fcs_pkg::fcs_off_option_copy) begin
			read_value = option_reg;
		end else if (haddr == fcs_pkg::fcs_off_configuration) begin
			read_value = config_value;
		end else if (haddr == fcs_pkg::fcs_off_status) begin
			read_value = status_value;
		end else begin
			read_value = 8'h00;
		end
	end

	// Security decode and key window decode.
	// Only code 2'b10 opens the device; the erased code stays secured.
	wire logic [1:0] sec_code = option_reg[1:0];
	wire logic key_enabled = option_reg[fcs_pkg::fcs_bit_key_enable];
	wire logic in_key_range = (flash_write_addr[15:3] ==
		fcs_pkg::fcs_key_base[15:3]);
	wire logic [2:0] key_idx = flash_write_addr[2:0];
	// Key writes only from secure firmware, never from debug. A debug write
	// in the window while key access is set is dropped altogether: it starts
	// no command either, so debug cannot probe the key through side effects.
	wire logic key_write = flash_write & in_key_range & key_access_reg &
		flash_write_from_secure & ~flash_write_from_debug;
	wire logic cmd_write = flash_write & ~(in_key_range & key_access_reg);
	wire logic key_ok = &key_seen_reg;
	// Clearing key access after all bytes matched unlocks, if key enabled.
	wire logic key_unlock = wr_cfg & key_access_reg &
		~hwdata[fcs_pkg::fcs_bit_key_access] & key_ok & key_enabled;
	wire logic [7:0] key_byte = stored_backdoor_key[{key_idx, 3'h0} +: 8];
	// Code that the option register will hold after this edge. The secured
	// flop decodes it, so the output moves in the same cycle as the code.
	wire logic unlock_event = key_unlock | blank_check_pass;
	wire logic [1:0] sec_code_next = unlock_event ?
		fcs_pkg::fcs_sec_unsecured : sec_code;
	wire logic secured_next =
		(sec_code_next != fcs_pkg::fcs_sec_unsecured);
	// While reset is held the decode follows the byte being copied in.
	wire logic secured_at_reset =
		(nonvolatile_option_byte[1:0] != fcs_pkg::fcs_sec_unsecured);
	// Expected next byte index is the count of bytes already accepted.
	// Counting accepted bytes instead of keeping a pointer lets a single
	// mismatch reset both the record and the order check in one step.
	logic [3:0] key_count;
	always_comb begin
		key_count = 4'h0;
		for (int i = 0; i < fcs_pkg::fcs_key_bytes; i++) begin
			key_count = key_count + {3'h0, key_seen_reg[i]};
		end
	end
	wire logic key_in_order = ({1'b0, key_idx} == key_count);

	// Bus address phase register; every access answers in zero waits, OKAY.
	// The read register returns to zero after its data phase, so a stale
	// value is never mistaken for a later answer.
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			addr_pend_reg <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= bus_take & hwrite;
			addr_pend_reg <= haddr;
			hrdata_reg <= (bus_take & ~hwrite) ? {24'h0, read_value} :
				32'h0000_0000;
		end
	end

	// Divider register is write-once; the flag sets on the first write.
	// Later writes answer OKAY but change nothing, so a runaway program
	// cannot retune the flash clock once it has been set.
	always_ff @(posedge clk) begin
		if (reset) begin
			divider_loaded_reg <= fcs_pkg::fcs_divider_reset[7];
			prescale_reg <= fcs_pkg::fcs_divider_reset[6];
			divisor_reg <= fcs_pkg::fcs_divider_reset[5:0];
		end else if (wr_div & ~divider_loaded_reg) begin
			divider_loaded_reg <= 1'b1;
			prescale_reg <= hwdata[fcs_pkg::fcs_bit_prescale];
			divisor_reg <= hwdata[fcs_pkg::fcs_div_msb:0];
		end
	end

	// Option copy follows the nonvolatile byte only while reset is held,
	// then only hardware unlock events may change the security code.
	// Software has no write path here: a new option byte needs a new reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			option_reg <= nonvolatile_option_byte;
		end else if (unlock_event) begin
			option_reg[1:0] <= fcs_pkg::fcs_sec_unsecured;
		end
	end

	// Key access bit and the per-byte match record. The record clears when
	// key access is switched on, so a half-entered key left over from an
	// earlier attempt can never complete a later one.
	always_ff @(posedge clk) begin
		if (reset) begin
			key_access_reg <= fcs_pkg::fcs_config_reset[5];
			key_seen_reg <= 8'h00;
			key_match_reg <= 1'b0;
		end else begin
			if (wr_cfg) begin
				key_access_reg <= hwdata[fcs_pkg::fcs_bit_key_access];
			end
			if (wr_cfg & hwdata[fcs_pkg::fcs_bit_key_access] &
				~key_access_reg) begin
				key_seen_reg <= 8'h00;
			end else if (key_write) begin
				// A wrong or out-of-order byte spoils the whole attempt.
				if (key_in_order & (flash_write_data == key_byte)) begin
					key_seen_reg[key_idx] <= 1'b1;
				end else begin
					key_seen_reg <= 8'h00;
				end
			end
			if (key_unlock) begin
				key_match_reg <= 1'b1;
			end
		end
	end

	// Command start and access error; the set wins over a same-cycle clear.
	// A command refused here never reaches the sequencer, which therefore
	// never runs with an unset flash clock.
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_start_reg <= 1'b0;
			access_error_reg <= 1'b0;
		end else begin
			cmd_start_reg <= cmd_write & divider_loaded_reg;
			if (cmd_write & ~divider_loaded_reg) begin
				access_error_reg <= 1'b1;
			end else if (wr_stat & hwdata[0]) begin
				access_error_reg <= 1'b0;
			end
		end
	end

	// Flash clock: optional divide by eight, then reload counter.
	// The prescaler runs always so its phase is arbitrary at first use.
	// The counter reloads on the tick that fires, so the period is exactly
	// the divisor plus one ticks, with no idle tick between periods.
	wire logic pre_tick = prescale_reg ? (pre_cnt_reg == 3'h0) : 1'b1;
	always_ff @(posedge clk) begin
		if (reset) begin
			pre_cnt_reg <= 3'h0;
			div_cnt_reg <= 6'h00;
			fclk_en_reg <= 1'b0;
		end else begin
			pre_cnt_reg <= pre_cnt_reg - 3'h1;
			fclk_en_reg <= 1'b0;
			if (divider_loaded_reg & pre_tick) begin
				if (div_cnt_reg == 6'h00) begin
					div_cnt_reg <= divisor_reg;
					fclk_en_reg <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg - 6'h01;
				end
			end
		end
	end

	// Access blocking flop for unsecured sources. The decision is a cycle
	// late, so the memory path must hold a request until it is known.
	always_ff @(posedge clk) begin
		if (reset) begin
			blocked_reg <= 1'b0;
		end else begin
			blocked_reg <= unsecured_access & secured_reg;
		end
	end

	// Secured flag flop, so the output leaves a flop like every other one.
	always_ff @(posedge clk) begin
		if (reset) begin
			secured_reg <= secured_at_reset;
		end else begin
			secured_reg <= secured_next;
		end
	end

	// Output assignments, all straight from flops. The slave never waits and
	// never reports an error, so its two answer signals are tied.
	assign hrdata = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign program_erase_enable = divider_loaded_reg;
	assign flash_clock_enable = fclk_en_reg;
	assign command_start = cmd_start_reg;
	assign access_error = access_error_reg;
	assign secured = secured_reg;
	assign backdoor_key_enable = option_reg[fcs_pkg::fcs_bit_key_enable];
	assign redirection_disable = option_reg[fcs_pkg::fcs_bit_redirect_dis];
	assign access_blocked = blocked_reg;
endmodule : fcs_flash_config

// >>> logic/fcs_pkg.sv
// Package of offsets, field positions and constants for the flash config block.
package fcs_pkg;
	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] fcs_off_clock_divider = 8'h00;
	localparam logic [7:0] fcs_off_option_copy = 8'h04;
	localparam logic [7:0] fcs_off_configuration = 8'h08;
	localparam logic [7:0] fcs_off_status = 8'h0c;
	// Field positions.
	localparam int fcs_bit_divider_loaded = 7;
	localparam int fcs_bit_prescale = 6;
	localparam int fcs_div_msb = 5;
	localparam int fcs_bit_key_enable = 7;
	localparam int fcs_bit_redirect_dis = 6;
	localparam int fcs_bit_key_access = 5;
	// Security code values.
	localparam logic [1:0] fcs_sec_unsecured = 2'h2;
	// Key address window, 0xffb0 to 0xffb7.
	localparam logic [15:0] fcs_key_base = 16'hffb0;
	localparam int fcs_key_bytes = 8;
	// Prescaler ratio for the divide-by-eight option.
	localparam int fcs_prescale_ratio = 8;
	// Reset values.
	localparam logic [7:0] fcs_divider_reset = 8'h00;
	localparam logic [7:0] fcs_config_reset = 8'h00;
	// AHB-Lite transfer type bit that marks an active transfer.
	localparam int fcs_htrans_active_bit = 1;
endpackage : fcs_pkg

// >>> verif/fcs_flash_config_props.sv
// Port checker for the flash clock and security configuration block.
`timescale 1ns/1ps
module fcs_flash_config_props (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Bus side.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Flash side.
	input wire logic flash_write,
	input wire logic [15:0] flash_write_addr,
	input wire logic blank_check_pass,
	input wire logic unsecured_access,
	// Outputs watched.
	input wire logic program_erase_enable,
	input wire logic flash_clock_enable,
	input wire logic command_start,
	input wire logic access_error,
	input wire logic secured,
	input wire logic backdoor_key_enable,
	input wire logic access_blocked
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Decodes of taken address phases to offset 0x00 and of writes outside the key range.
	wire logic take = hsel && hready && htrans[1] && haddr == 8'h00;
	wire logic wr0 = take && hwrite;
	wire logic rd0 = take && !hwrite;
	wire logic nk = flash_write && flash_write_addr[15:3] != 13'h1ff6;
	property p_bus; hreadyout && !hresp; endproperty
	a_bus: assert property (p_bus) else $error("bus answer not OKAY");
	property p_load; wr0 && !program_erase_enable |-> ##2 program_erase_enable;
	endproperty
	a_load: assert property (p_load) else $error("first write no load");
	property p_keep; program_erase_enable |=> program_erase_enable; endproperty
	a_keep: assert property (p_keep) else $error("enable dropped");
	property p_err; nk && !program_erase_enable |=> access_error && !command_start;
	endproperty
	a_err: assert property (p_err) else $error("early command taken");
	property p_cmd; nk && program_erase_enable |=> command_start; endproperty
	a_cmd: assert property (p_cmd) else $error("command not started");
	property p_cause;
		command_start |-> $past(flash_write && program_erase_enable);
	endproperty
	a_cause: assert property (p_cause) else $error("stray command");
	property p_lock;
		secured && !backdoor_key_enable && !blank_check_pass |=> secured;
	endproperty
	a_lock: assert property (p_lock) else $error("unlocked with key off");
	property p_blank; blank_check_pass |=> !secured; endproperty
	a_blank: assert property (p_blank) else $error("blank check kept lock");
	property p_blk; unsecured_access && secured |=> access_blocked; endproperty
	a_blk: assert property (p_blk) else $error("access not blocked");
	property p_opt; $stable(backdoor_key_enable); endproperty
	a_opt: assert property (p_opt) else $error("option changed");
	property p_fclk; !program_erase_enable |-> !flash_clock_enable; endproperty
	a_fclk: assert property (p_fclk) else $error("clock before load");
	property p_rd;
		rd0 |=> hrdata[7] == $past(program_erase_enable);
	endproperty
	a_rd: assert property (p_rd) else $error("loaded flag misread");
	// Main scenarios reached.
	c_cmd: cover property (command_start);
	c_fclk: cover property (flash_clock_enable);
	c_unlock: cover property ($fell(secured));
endmodule : fcs_flash_config_props

// >>> verif/tb.sv
// Self-checking bench for the flash clock and security configuration block.
`timescale 1ns/1ps
module tb;
	logic clk = 0, reset = 1, hsel = 0, hwrite = 0, flash_write = 0;
	logic flash_write_from_debug = 0, flash_write_from_secure = 0;
	logic blank_check_pass = 0, unsecured_access = 0;
	logic [7:0] haddr = 0, nonvolatile_option_byte = 0, flash_write_data = 0;
	logic [31:0] rd_q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata;
	logic [15:0] flash_write_addr = 0;
	logic [63:0] stored_backdoor_key = 0;
	wire logic hreadyout, hresp, program_erase_enable, flash_clock_enable;
	wire logic command_start, access_error, secured, backdoor_key_enable;
	wire logic redirection_disable, access_blocked;
	wire logic hready = hreadyout;
	int num_errors = 0, n_compared = 0, cyc = 0;
	fcs_flash_config uut (
		.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .nonvolatile_option_byte(nonvolatile_option_byte),
		.stored_backdoor_key(stored_backdoor_key),
		.flash_write(flash_write), .flash_write_addr(flash_write_addr),
		.flash_write_data(flash_write_data),
		.flash_write_from_debug(flash_write_from_debug),
		.flash_write_from_secure(flash_write_from_secure),
		.blank_check_pass(blank_check_pass),
		.unsecured_access(unsecured_access),
		.program_erase_enable(program_erase_enable),
		.flash_clock_enable(flash_clock_enable),
		.command_start(command_start), .access_error(access_error),
		.secured(secured), .backdoor_key_enable(backdoor_key_enable),
		.redirection_disable(redirection_disable),
		.access_blocked(access_blocked)
	);
	// Clock.
	initial begin
		forever #2 clk = ~clk;
	end
	// Read capture at the edge, random unsecured traffic and the hang limit.
	always @(posedge clk) begin
		rd_q <= hrdata;
		unsecured_access <= 1'($urandom);
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; read data is the value captured at the data edge.
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		#1;
		r = rd_q;
	endtask : ahb
	// One flash-side write; calls leave an idle cycle between writes.
	task automatic fwr(input logic [15:0] a, input logic [7:0] d, input logic bd);
		@(posedge clk);
		flash_write <= 1;
		flash_write_addr <= a;
		flash_write_data <= d;
		flash_write_from_debug <= bd;
		flash_write_from_secure <= !bd;
		@(posedge clk);
		flash_write <= 0;
		#1;
	endtask : fwr
	// Edges from one clock enable to the next, bounded.
	task automatic period(output int n);
		n = 0;
		while (flash_clock_enable !== 1'b1 && n < 900) begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (flash_clock_enable !== 1'b1 && n < 900);
	endtask : period
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// Each pass: new option byte and key, reset, then every register path.
	initial begin
		logic [31:0] r;
		logic [7:0] dv;
		int n;
		n = $urandom(29012);
		for (int p = 0; p < 4; p++) begin
			@(posedge clk);
			nonvolatile_option_byte <= {p != 3, 1'($urandom), 4'h0, 2'(p)};
			stored_backdoor_key <= {$urandom, $urandom};
			reset <= 1;
			repeat (12) @(posedge clk);
			reset <= 0;
			#1;
			chk(secured, p != 2);
			chk(redirection_disable, nonvolatile_option_byte[6]);
			chk(backdoor_key_enable, p != 3);
			ahb(0, 8'h04, 0, r);
			chk(r, nonvolatile_option_byte);
			ahb(0, 8'h08, 0, r);
			chk(r, 0);
			ahb(0, 8'h10, 0, r);
			chk(r, 0);
			fwr(16'h1000, 8'h20, 0);
			chk({command_start, access_error}, 2'h1);
			// Small divisors keep the run short; at its real bus rate software
			// picks the setting that puts the flash clock in its window.
			dv = {1'($urandom), 1'(p & 1), 6'($urandom_range(5))};
			ahb(1, 8'h00, dv, r);
			ahb(1, 8'h00, ~dv, r);
			ahb(0, 8'h00, 0, r);
			chk(r, dv | 8'h80);
			chk(program_erase_enable, 1);
			period(n);
			chk(32'(n), (dv[5:0] + 1) * (dv[6] ? 8 : 1));
			ahb(1, 8'h0c, 32'h1, r);
			ahb(0, 8'h0c, 0, r);
			chk(r, 0);
			fwr(16'hffb0 + 16'(p), 8'h20, 0);
			chk({command_start, access_error}, 2'h2);
			ahb(1, 8'h08, 32'h20, r);
			// Pass 1 enters from debug and pass 2 spoils one byte.
			for (int i = 0; i < 8; i++) begin
				fwr(16'hffb0 + 16'(i), stored_backdoor_key[8*i +: 8] ^
					8'(p == 2 && i == 3), p == 1);
				chk(command_start, 0);
			end
			ahb(1, 8'h08, 0, r);
			@(posedge clk);
			#1;
			chk(secured, p == 1 || p == 3);
			ahb(0, 8'h0c, 0, r);
			chk(r, {30'h0, p == 0, 1'b0});
			@(posedge clk);
			blank_check_pass <= 1;
			@(posedge clk);
			blank_check_pass <= 0;
			#1;
			chk(secured, 0);
			$display("pass %0d done", p);
		end
		tally_and_finish();
	end
endmodule : tb
bind fcs_flash_config fcs_flash_config_props u_props (
	.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .flash_write(flash_write),
	.flash_write_addr(flash_write_addr), .blank_check_pass(blank_check_pass),
	.unsecured_access(unsecured_access),
	.program_erase_enable(program_erase_enable),
	.flash_clock_enable(flash_clock_enable), .command_start(command_start),
	.access_error(access_error), .secured(secured),
	.backdoor_key_enable(backdoor_key_enable),
	.access_blocked(access_blocked)
);
